// ===== rtl/guard_lock_teach_control.sv
// module: teach-in, lock drive and safety output control of a guard lock
// How it works
// - a standard coded unit accepts any actuator and runs from reset with no teach-in.
// - an individually coded unit starts teach-in only after a power cycle and a fresh actuator detection.
// - during teach-in green is off, red is on and yellow flashes at 1 Hz.
// - after 10 s of teach-in yellow flashes briefly at 3 Hz to ask for a power removal.
// - without power removal within 5 min teach-in is dropped and red flashes five times.
// - after power returns the learned code is made active and stored only once an actuator with that code is detected.
// - the single-teach unit keeps its first pairing forever and refuses any later teach-in.
// - the repeat-teach unit may teach again at will and each new code replaces the old one.
// - after a new code the repeat-teach unit holds a ten minute inhibit with green flashing.
// - a power loss during the inhibit restarts the full inhibit after power returns.
// - power-to-unlock: control input high unlocks, low locks.
// - power-to-lock: control input high locks, low unlocks.
// - lock-monitoring outputs drop both safety outputs whenever the lock is released.
// - lock-monitoring outputs come back on relock with the actuator still inserted.
// - guard-monitoring outputs drop only when the guard is opened.
`timescale 1ns/1ps
module guard_lock_teach_control #(
    parameter int unsigned TICK_CYCLES = guard_lock_pkg::SEC_CYCLES,    // cycles per second tick
    parameter int unsigned SLOW_HALF   = guard_lock_pkg::SLOW_HALF_CYC, // 1 Hz half period
    parameter int unsigned FAST_HALF   = guard_lock_pkg::FAST_HALF_CYC  // 3 Hz half period
) (
    input  wire logic                              clk_in,            // system clock
    input  wire logic                              reset_in,          // power-on, sync high
    input  wire logic                              individual_code_in, // 1: individually coded
    input  wire logic                              repeat_teach_variant_in, // 1: repeat, 0: single
    input  wire logic                              power_to_lock_in,  // 1: power-to-lock variant
    input  wire logic                              guard_monitor_in,  // 1: guard-monitoring outputs
    input  wire logic                              solenoid_ctrl_in,  // control pin (async)
    input  wire logic                              actuator_valid_in, // actuator read (async)
    input  wire logic [guard_lock_pkg::CODE_W-1:0] actuator_code_in,  // code read, stable with valid
    input  wire logic                              bolt_locked_in,    // bolt home sense (async)
    input  wire logic                              safety_input_one_in, // chain input 1 (async)
    input  wire logic                              safety_input_two_in, // chain input 2 (async)
    input  wire guard_lock_pkg::nv_s               nv_in,             // stored state at power-up
    output guard_lock_pkg::nv_s                    nv_out,            // state to keep in storage
    output logic                                   nv_write_out,      // pulse: store nv_out
    output logic                                   lock_drive_out,    // 1: drive bolt to lock
    output logic                                   safety_output_one_out, // safety output 1
    output logic                                   safety_output_two_out, // safety output 2
    output guard_lock_pkg::led_s                   led_out,           // indicator drive
    output logic                                   teach_active_out   // teach-in running
);
    // ==========================================================
    // input synchronisers
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    always_ff @(posedge clk_in) begin
        s1_reg <= {solenoid_ctrl_in, actuator_valid_in, bolt_locked_in, safety_input_one_in, safety_input_two_in};
        s2_reg <= s1_reg;
    end
    wire ctrl_s    = s2_reg[4];
    wire act_s     = s2_reg[3];
    wire bolt_s    = s2_reg[2];
    wire chain_s   = s2_reg[1] & s2_reg[0];

    // ==========================================================
    // timing enables
    logic sec_tick;
    logic slow_tick;
    logic fast_tick;
    logic restart_timers;
    tick_divider #(.PERIOD(TICK_CYCLES)) u_sec (
        .clk_in(clk_in), .reset_in(reset_in), .restart_in(restart_timers), .tick_out(sec_tick));
    tick_divider #(.PERIOD(SLOW_HALF)) u_slow (
        .clk_in(clk_in), .reset_in(reset_in), .restart_in(1'b0), .tick_out(slow_tick));
    tick_divider #(.PERIOD(FAST_HALF)) u_fast (
        .clk_in(clk_in), .reset_in(reset_in), .restart_in(1'b0), .tick_out(fast_tick));

    // ==========================================================
    // state
    guard_lock_pkg::teach_state_e state_reg;
    guard_lock_pkg::teach_state_e state_next;
    guard_lock_pkg::nv_s          nv_reg;
    guard_lock_pkg::nv_s          nv_next;
    logic [guard_lock_pkg::SEC_W-1:0]  sec_reg;
    logic [guard_lock_pkg::CODE_W-1:0] learn_reg;
    logic                              act_prev_reg;
    logic                              slow_reg;
    logic                              fast_reg;
    logic [3:0]                        flash_cnt_reg;
    logic                              nv_loaded_reg;
    logic                              fresh_reg;

    localparam logic [guard_lock_pkg::SEC_W-1:0] T_TEACH  = guard_lock_pkg::SEC_W'(guard_lock_pkg::TEACH_RUN_SEC);
    localparam logic [guard_lock_pkg::SEC_W-1:0] T_REMOVE = guard_lock_pkg::SEC_W'(guard_lock_pkg::REMOVE_WAIT_SEC);
    localparam logic [guard_lock_pkg::SEC_W-1:0] T_INHIB  = guard_lock_pkg::SEC_W'(guard_lock_pkg::INHIBIT_SEC);
    localparam logic [3:0] RED_EDGES = 4'(2 * guard_lock_pkg::RED_FLASH_COUNT);

    wire act_rise    = act_s & ~act_prev_reg;
    wire code_match  = ~individual_code_in | (nv_reg.paired & (learn_reg == nv_reg.code));
    wire may_teach   = individual_code_in & (~nv_reg.paired | repeat_teach_variant_in);
    wire new_code    = act_s & (actuator_code_in != nv_reg.code);
    wire state_chg   = (state_next != state_reg);

    // ==========================================================
    // teach-in sequence
    always_comb begin
        state_next     = state_reg;
        nv_next        = nv_reg;
        restart_timers = state_chg;
        case (state_reg)
            guard_lock_pkg::ST_BOOT: begin
                if (nv_reg.inhibit) begin
                    state_next = guard_lock_pkg::ST_INHIBIT;
                end else if (nv_reg.teach_pending) begin
                    state_next = guard_lock_pkg::ST_CONFIRM;
                end else begin
                    state_next = guard_lock_pkg::ST_RUN;
                end
            end
            guard_lock_pkg::ST_RUN: begin
                // only the first detection after power-up may open teach-in
                if (act_rise && nv_loaded_reg && fresh_reg && may_teach && (new_code || !nv_reg.paired)) begin
                    state_next = guard_lock_pkg::ST_TEACH;
                end
            end
            guard_lock_pkg::ST_TEACH: begin
                if (sec_tick && sec_reg == T_TEACH - guard_lock_pkg::SEC_W'(1)) begin
                    state_next = guard_lock_pkg::ST_REMOVE_REQ;
                    nv_next.teach_pending = 1'b1;
                    // the learned code has to outlive the power cycle that confirms it
                    nv_next.pending_code  = learn_reg;
                end
            end
            guard_lock_pkg::ST_REMOVE_REQ: begin
                if (sec_tick && sec_reg == T_REMOVE - guard_lock_pkg::SEC_W'(1)) begin
                    state_next = guard_lock_pkg::ST_ABORT;
                    nv_next.teach_pending = 1'b0;
                end
            end
            guard_lock_pkg::ST_ABORT: begin
                if (flash_cnt_reg == RED_EDGES) begin
                    state_next = guard_lock_pkg::ST_RUN;
                end
            end
            guard_lock_pkg::ST_CONFIRM: begin
                if (act_s && actuator_code_in == learn_reg) begin
                    nv_next.code          = learn_reg;
                    nv_next.paired        = 1'b1;
                    nv_next.teach_pending = 1'b0;
                    nv_next.inhibit       = repeat_teach_variant_in;
                    state_next = repeat_teach_variant_in ? guard_lock_pkg::ST_INHIBIT : guard_lock_pkg::ST_RUN;
                end
            end
            guard_lock_pkg::ST_INHIBIT: begin
                if (sec_reg >= T_INHIB && act_s) begin
                    nv_next.inhibit = 1'b0;
                    state_next = guard_lock_pkg::ST_RUN;
                end
            end
            default: state_next = guard_lock_pkg::ST_BOOT;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg     <= guard_lock_pkg::ST_BOOT;
            nv_reg        <= '0;
            nv_loaded_reg <= 1'b0;
            nv_write_out  <= 1'b0;
        end else if (!nv_loaded_reg) begin
            nv_reg        <= nv_in;
            nv_loaded_reg <= 1'b1;
            nv_write_out  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            nv_reg       <= nv_next;
            nv_write_out <= (nv_next != nv_reg);
        end
    end
    assign nv_out = nv_reg;

    // seconds spent in the current state; inhibit restarts from zero at boot
    always_ff @(posedge clk_in) begin
        if (reset_in || restart_timers) begin
            sec_reg <= '0;
        end else if (sec_tick && sec_reg != {guard_lock_pkg::SEC_W{1'b1}}) begin
            sec_reg <= sec_reg + guard_lock_pkg::SEC_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            act_prev_reg <= 1'b1;
            learn_reg    <= '0;
            fresh_reg    <= 1'b1;
        end else begin
            act_prev_reg <= act_s;
            // a later detection without a power cycle must not open teach-in
            if (act_rise) begin
                fresh_reg <= 1'b0;
            end
            if (state_reg == guard_lock_pkg::ST_RUN && state_next == guard_lock_pkg::ST_TEACH) begin
                learn_reg <= actuator_code_in;
            end else if (state_reg == guard_lock_pkg::ST_BOOT) begin
                learn_reg <= nv_reg.teach_pending ? nv_reg.pending_code : nv_reg.code;
            end else if (state_reg == guard_lock_pkg::ST_RUN && act_rise) begin
                learn_reg <= actuator_code_in;
            end
        end
    end

    // ==========================================================
    // flashing
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            slow_reg      <= 1'b0;
            fast_reg      <= 1'b0;
            flash_cnt_reg <= '0;
        end else begin
            if (slow_tick) slow_reg <= ~slow_reg;
            if (fast_tick) fast_reg <= ~fast_reg;
            if (state_reg != guard_lock_pkg::ST_ABORT) begin
                flash_cnt_reg <= '0;
            end else if (slow_tick && flash_cnt_reg != RED_EDGES) begin
                flash_cnt_reg <= flash_cnt_reg + 4'(1);
            end
        end
    end

    // ==========================================================
    // lock and outputs
    wire in_teach  = (state_reg == guard_lock_pkg::ST_TEACH) || (state_reg == guard_lock_pkg::ST_REMOVE_REQ);
    wire blocked   = in_teach || (state_reg != guard_lock_pkg::ST_RUN);
    wire want_lock = power_to_lock_in ? ctrl_s : ~ctrl_s;
    wire ok_base   = ~blocked & chain_s & act_s & code_match;
    // lock mode needs bolt home; guard mode only needs the actuator in
    wire ok_out    = guard_monitor_in ? ok_base : (ok_base & bolt_s);
    // odd counts are lit so exactly five pulses show, whatever the free running phase
    wire red_on    = in_teach || (state_reg == guard_lock_pkg::ST_ABORT && flash_cnt_reg[0]);
    wire yel_on    = (state_reg == guard_lock_pkg::ST_TEACH) ? slow_reg :
                     (state_reg == guard_lock_pkg::ST_REMOVE_REQ) ? (fast_reg & slow_reg) :
                     (state_reg == guard_lock_pkg::ST_RUN) ? (act_s & bolt_s) : 1'b0;
    wire grn_on    = in_teach ? 1'b0 :
                     (state_reg == guard_lock_pkg::ST_INHIBIT) ? slow_reg : 1'b1;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            lock_drive_out        <= 1'b0;
            safety_output_one_out <= 1'b0;
            safety_output_two_out <= 1'b0;
            led_out               <= '0;
            teach_active_out      <= 1'b0;
        end else begin
            lock_drive_out        <= want_lock & act_s;
            safety_output_one_out <= ok_out;
            safety_output_two_out <= ok_out;
            led_out               <= '{green: grn_on, red: red_on, yellow: yel_on};
            teach_active_out      <= in_teach;
        end
    end

    // ==========================================================
    // checks
    property p_teach_outputs_off;
        @(posedge clk_in) disable iff (reset_in) in_teach |=> !safety_output_one_out && !safety_output_two_out;
    endproperty
    a_teach_outputs_off: assert property (p_teach_outputs_off) else $error("output on during teach");

    property p_teach_leds;
        @(posedge clk_in) disable iff (reset_in)
            (state_reg == guard_lock_pkg::ST_TEACH) |=> !led_out.green && led_out.red;
    endproperty
    a_teach_leds: assert property (p_teach_leds) else $error("teach indicator wrong");

    property p_single_refuse;
        @(posedge clk_in) disable iff (reset_in)
            (!repeat_teach_variant_in && nv_reg.paired && state_reg == guard_lock_pkg::ST_RUN)
            |=> state_reg != guard_lock_pkg::ST_TEACH;
    endproperty
    a_single_refuse: assert property (p_single_refuse) else $error("single unit re-taught");

    property p_lock_drop;
        @(posedge clk_in) disable iff (reset_in)
            (!guard_monitor_in && !bolt_s) |=> !safety_output_one_out;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("output on while unlocked");

    property p_guard_mode_hold;
        @(posedge clk_in) disable iff (reset_in)
            (guard_monitor_in && ok_base) |=> safety_output_one_out && safety_output_two_out;
    endproperty
    a_guard_mode_hold: assert property (p_guard_mode_hold) else $error("guard mode dropped");

    property p_lock_polarity;
        @(posedge clk_in) disable iff (reset_in)
            (act_s && !reset_in) |=> lock_drive_out == ($past(power_to_lock_in) ? $past(ctrl_s) : !$past(ctrl_s));
    endproperty
    a_lock_polarity: assert property (p_lock_polarity) else $error("lock polarity wrong");

    property p_inhibit_off;
        @(posedge clk_in) disable iff (reset_in)
            (state_reg == guard_lock_pkg::ST_INHIBIT) |=> !safety_output_two_out;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("output on during inhibit");

    property p_confirm_store;
        @(posedge clk_in) disable iff (reset_in)
            (state_reg == guard_lock_pkg::ST_CONFIRM && state_next != guard_lock_pkg::ST_CONFIRM)
            |=> nv_reg.paired && nv_write_out;
    endproperty
    a_confirm_store: assert property (p_confirm_store) else $error("code not stored");
endmodule : guard_lock_teach_control

// ===== rtl/guard_lock_pkg.sv
// package: constants, types and timing of the guard lock teach-in control
package guard_lock_pkg;

    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned TEACH_RUN_S     = 10;
    localparam int unsigned REMOVE_WAIT_MIN = 5;
    localparam int unsigned INHIBIT_MIN     = 10;
    localparam int unsigned SLOW_FLASH_HZ   = 1;
    localparam int unsigned FAST_FLASH_HZ   = 3;
    localparam int unsigned RED_FLASH_COUNT = 5;
    localparam int unsigned SEC_PER_MIN     = 60;

    localparam int unsigned CODE_W = 32;
    localparam int unsigned SEC_W  = 10;
    localparam int unsigned CYC_W  = 28;

    // derived counts
    localparam int unsigned TEACH_RUN_SEC   = TEACH_RUN_S;
    localparam int unsigned REMOVE_WAIT_SEC = REMOVE_WAIT_MIN * SEC_PER_MIN;
    localparam int unsigned INHIBIT_SEC     = INHIBIT_MIN * SEC_PER_MIN;
    localparam int unsigned SEC_CYCLES      = CLK_HZ;
    localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_FLASH_HZ);
    localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (2 * FAST_FLASH_HZ);

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_RUN,
        ST_TEACH,
        ST_REMOVE_REQ,
        ST_ABORT,
        ST_CONFIRM,
        ST_INHIBIT
    } teach_state_e;

    typedef struct packed {
        logic green;
        logic red;
        logic yellow;
    } led_s;

    typedef struct packed {
        logic                teach_pending;
        logic                paired;
        logic                inhibit;
        logic [CODE_W-1:0]   code;
        logic [CODE_W-1:0]   pending_code;
    } nv_s;

endpackage : guard_lock_pkg

// ===== rtl/tick_divider.sv
// module: free running divider giving one-cycle enable pulses
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned PERIOD = 200_000_000
) (
    input  wire logic clk_in,     // system clock
    input  wire logic reset_in,   // synchronous reset
    input  wire logic restart_in, // restart count from zero
    output logic      tick_out    // one-cycle pulse per period
);
    localparam int unsigned CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count_reg;
    wire           wrap = (count_reg == LAST);

    always_ff @(posedge clk_in) begin
        if (reset_in || restart_in || wrap) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || restart_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= wrap;
        end
    end
endmodule : tick_divider

// ===== tb/lock_controller_model.sv
// partner model: safety controller that drives the solenoid control pin and watches the safety outputs
`timescale 1ns/1ps
module lock_controller_model (
    input  wire logic clk_in,           // system clock
    input  wire logic want_lock_in,     // controller wishes the guard locked
    input  wire logic power_to_lock_in, // variant strap seen by the controller
    input  wire logic safety_one_in,    // safety output 1 of the lock
    input  wire logic safety_two_in,    // safety output 2 of the lock
    output logic      solenoid_ctrl_out, // control pin level
    output logic      outputs_ok_out     // both safety channels enabled
);
    // =====================================================
    // control pin polarity
    initial solenoid_ctrl_out = 1'b1;
    // the pin changes only after an edge, like a real controller output stage
    always @(posedge clk_in) begin
        if (power_to_lock_in) begin
            solenoid_ctrl_out <= want_lock_in;
        end else begin
            solenoid_ctrl_out <= ~want_lock_in;
        end
    end
    // =====================================================
    // dual channel reading
    assign outputs_ok_out = safety_one_in & safety_two_in;
endmodule : lock_controller_model

// ===== tb/guard_lock_teach_control_bench.sv
// testbench: teach-in, lock drive and safety output behaviour of the guard lock control
`timescale 1ns/1ps
module guard_lock_teach_control_bench;
    localparam int unsigned TICK = 50;
    localparam int unsigned SLOW = 10;
    localparam int unsigned FAST = 4;
    localparam logic [31:0] CODE_A = 32'h1234_abcd;
    localparam logic [31:0] CODE_B = 32'h0bad_f00d;
    logic clk_in = 1'b0, reset_in = 1'b1, individual_code_in = 1'b0, repeat_teach_variant_in = 1'b1;
    logic power_to_lock_in = 1'b0, guard_monitor_in = 1'b0, actuator_valid_in = 1'b0, bolt_locked_in = 1'b0;
    logic want_lock = 1'b1, solenoid_ctrl_in, outputs_ok;
    logic [31:0] actuator_code_in = 32'h0;
    guard_lock_pkg::nv_s nv_store = '0;
    guard_lock_pkg::nv_s nv_out;
    guard_lock_pkg::led_s led_out;
    logic nv_write_out, lock_drive_out, safety_output_one_out, safety_output_two_out, teach_active_out;
    int errors = 0, total_checks = 0, c, falls, run;
    always #2.5 clk_in = ~clk_in;
    guard_lock_teach_control #(.TICK_CYCLES(TICK), .SLOW_HALF(SLOW), .FAST_HALF(FAST)) guard_lock_teach_control_i (
        .clk_in(clk_in), .reset_in(reset_in), .individual_code_in(individual_code_in),
        .repeat_teach_variant_in(repeat_teach_variant_in), .power_to_lock_in(power_to_lock_in),
        .guard_monitor_in(guard_monitor_in), .solenoid_ctrl_in(solenoid_ctrl_in),
        .actuator_valid_in(actuator_valid_in), .actuator_code_in(actuator_code_in),
        .bolt_locked_in(bolt_locked_in), .safety_input_one_in(1'b1), .safety_input_two_in(1'b1),
        .nv_in(nv_store), .nv_out(nv_out), .nv_write_out(nv_write_out), .lock_drive_out(lock_drive_out),
        .safety_output_one_out(safety_output_one_out), .safety_output_two_out(safety_output_two_out),
        .led_out(led_out), .teach_active_out(teach_active_out));
    lock_controller_model lock_controller_model_i (
        .clk_in(clk_in), .want_lock_in(want_lock), .power_to_lock_in(power_to_lock_in),
        .safety_one_in(safety_output_one_out), .safety_two_in(safety_output_two_out),
        .solenoid_ctrl_out(solenoid_ctrl_in), .outputs_ok_out(outputs_ok));
    // =====================================================
    // storage and mechanics stand-ins: storage keeps what the block writes, the bolt follows the drive
    always @(posedge clk_in) begin
        if (nv_write_out === 1'b1) begin
            nv_store <= nv_out;
        end
        bolt_locked_in <= lock_drive_out & actuator_valid_in;
    end
    // =====================================================
    // tasks
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc
    task automatic power_cycle;
        @(posedge clk_in);
        reset_in <= 1'b1;
        wait_cyc(5);
        @(posedge clk_in);
        reset_in <= 1'b0;
        wait_cyc(4);
    endtask : power_cycle
    task automatic insert(input logic [31:0] code);
        @(posedge clk_in);
        actuator_code_in <= code;
        actuator_valid_in <= 1'b1;
    endtask : insert
    task automatic withdraw;
        @(posedge clk_in);
        actuator_valid_in <= 1'b0;
        wait_cyc(10);
    endtask : withdraw
    // sel 0 yellow, 1 red, 2 green: counts falling edges and the longest lit run
    task automatic watch(input int sel, input int n, output int nf, output int nr);
        logic prev, cur;
        int r;
        nf = 0;
        nr = 0;
        r = 0;
        prev = 1'b0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            cur = (sel == 0) ? led_out.yellow : (sel == 1) ? led_out.red : led_out.green;
            if (prev && !cur) nf++;
            r = cur ? r + 1 : 0;
            if (r > nr) nr = r;
            prev = cur;
        end
    endtask : watch
    // counts cycles until the sampled flag reaches the wanted level, bounded
    task automatic time_to(input int sel, input logic lvl, input int lim, output int n);
        n = 0;
        while (n < lim && ((sel == 0 ? safety_output_one_out : teach_active_out) !== lvl)) begin
            wait_cyc(1);
            n++;
        end
    endtask : time_to
    // =====================================================
    // watchdog: the tests take about 62k cycles
    initial begin
        repeat (100000) @(posedge clk_in);
        errors++;
        report_and_stop();
    end
    // =====================================================
    // tests
    initial begin
        // standard coded unit, power-to-unlock, lock-monitoring outputs
        power_cycle();
        insert(CODE_A);
        wait_cyc(20);
        check_val(teach_active_out, 1'b0);
        check_val(lock_drive_out, 1'b1);
        check_val(outputs_ok, 1'b1);
        @(posedge clk_in) want_lock <= 1'b0;
        wait_cyc(20);
        check_val(lock_drive_out, 1'b0);
        check_val({safety_output_one_out, safety_output_two_out}, 2'b00);
        @(posedge clk_in) want_lock <= 1'b1;
        wait_cyc(20);
        check_val({safety_output_one_out, safety_output_two_out}, 2'b11);
        // guard-monitoring outputs drop on opening only
        @(posedge clk_in) guard_monitor_in <= 1'b1;
        power_cycle();
        wait_cyc(20);
        @(posedge clk_in) want_lock <= 1'b0;
        wait_cyc(20);
        check_val(outputs_ok, 1'b1);
        withdraw();
        wait_cyc(10);
        check_val(outputs_ok, 1'b0);
        // power-to-lock polarity
        @(posedge clk_in) guard_monitor_in <= 1'b0;
        power_to_lock_in <= 1'b1;
        want_lock <= 1'b1;
        power_cycle();
        insert(CODE_A);
        wait_cyc(20);
        check_val({solenoid_ctrl_in, lock_drive_out}, 2'b11);
        @(posedge clk_in) want_lock <= 1'b0;
        wait_cyc(20);
        check_val({solenoid_ctrl_in, lock_drive_out}, 2'b00);
        // individually coded, repeat-teach: teach CODE_A
        @(posedge clk_in) power_to_lock_in <= 1'b0;
        want_lock <= 1'b1;
        individual_code_in <= 1'b1;
        withdraw();
        power_cycle();
        insert(CODE_A);
        wait_cyc(100);
        check_val({teach_active_out, led_out.green, led_out.red}, 3'b101);
        check_val(outputs_ok, 1'b0);
        watch(0, 80, falls, run);
        check_val(run, SLOW);
        wait_cyc(10 * TICK);
        watch(0, 40, falls, run);
        check_val(run <= FAST && falls > 0, 1'b1);
        withdraw();
        power_cycle();
        check_val(nv_store.code, 32'h0);
        insert(CODE_A);
        wait_cyc(50);
        check_val(nv_store.code, CODE_A);
        watch(2, 40, falls, run);
        check_val(falls > 0, 1'b1);
        wait_cyc(300 * TICK);
        check_val(outputs_ok, 1'b0);
        // power loss half way through the inhibit restarts it in full
        power_cycle();
        time_to(0, 1'b1, 620 * TICK, c);
        check_val(c > 598 * TICK && c < 602 * TICK, 1'b1);
        check_val(outputs_ok, 1'b1);
        // a second teach with another code, left to run out
        withdraw();
        insert(CODE_B);
        wait_cyc(20);
        check_val(teach_active_out, 1'b1);
        time_to(1, 1'b0, 320 * TICK, c);
        check_val(c > 308 * TICK && c < 312 * TICK, 1'b1);
        watch(1, 250, falls, run);
        check_val(falls, 5);
        check_val(nv_store.code, CODE_A);
        // a fresh insertion without a power cycle starts nothing
        withdraw();
        insert(CODE_B);
        wait_cyc(20);
        check_val(teach_active_out, 1'b0);
        // single-teach unit already paired refuses a new actuator
        withdraw();
        @(posedge clk_in) repeat_teach_variant_in <= 1'b0;
        nv_store <= '{teach_pending: 1'b0, paired: 1'b1, inhibit: 1'b0, code: CODE_A, pending_code: 32'h0};
        power_cycle();
        insert(CODE_B);
        wait_cyc(30);
        check_val(teach_active_out, 1'b0);
        check_val(outputs_ok, 1'b0);
        report_and_stop();
    end
endmodule : guard_lock_teach_control_bench
